// ===== hdl/rtcs_defines.vh
// Purpose: Shared constants of the serial real-time clock core
// Assumes: Included by bare name from the top design file only
// Notes: Definitions only
`ifndef RTCS_DEFINES_VH
`define RTCS_DEFINES_VH

// Register indices of the time and calendar bytes
`define RTCS_IDX_SEC 7'h00
`define RTCS_IDX_MIN 7'h01
`define RTCS_IDX_HOUR 7'h02
`define RTCS_IDX_DOW 7'h03
`define RTCS_IDX_DATE 7'h04
`define RTCS_IDX_MON 7'h05
`define RTCS_IDX_YEAR 7'h06
`define RTCS_NUM_TIME 7'h07

// Bits that exist in each register; the rest read zero
`define RTCS_MASK_SEC 8'h7f
`define RTCS_MASK_MIN 8'h7f
`define RTCS_MASK_HOUR 8'h7f
`define RTCS_MASK_DOW 8'h07
`define RTCS_MASK_DATE 8'h3f
`define RTCS_MASK_MON 8'h1f
`define RTCS_MASK_YEAR 8'hff

// Hours field positions
`define RTCS_HOUR_MODE_BIT 6
`define RTCS_HOUR_PM_BIT 5

// Address byte: write flag position
`define RTCS_ADDR_WR_BIT 7

// Oscillator division to one second
`define RTCS_OSC_HZ 32768
`define RTCS_PRESC_MAX 15'h7fff

// Write buffer shape
`define RTCS_FIFO_W 15
`define RTCS_FIFO_D 8
`define RTCS_FIFO_AW 3

`endif

// ===== hdl/rtcs_fifo.v
// Purpose: Small flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is two to the power AW
// Notes: Full and empty come from an occupancy count
`timescale 1ns/100ps
module rtcs_fifo #(
    parameter W = 15,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [W-1:0] in_data,
    // Drain side
    output wire out_valid,
    input wire out_ready,
    output wire [W-1:0] out_data
);

reg [W-1:0] mem_reg [0:DEPTH-1];
reg [AW-1:0] wr_ptr_reg;
reg [AW-1:0] rd_ptr_reg;
reg [AW:0] count_reg;
wire push;
wire pop;

assign in_ready = (count_reg != DEPTH[AW:0]);
assign out_valid = (count_reg != {(AW+1){1'b0}});
assign out_data = mem_reg[rd_ptr_reg];
assign push = in_valid & in_ready;
assign pop = out_valid & out_ready;

always @(posedge clk) begin
    if (push) begin
        mem_reg[wr_ptr_reg] <= in_data;
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
    end else begin
        if (push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
        end
        if (push & ~pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop & ~push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
end

endmodule

// ===== hdl/rtcs_sync.v
// Purpose: Two-stage synchroniser for asynchronous levels
// Assumes: Inputs come from outside the clk domain
// Notes: Only the second stage may be read
`timescale 1ns/100ps
module rtcs_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Levels
    input wire [W-1:0] async_in,
    output wire [W-1:0] sync_out
);

reg [W-1:0] meta_reg;
reg [W-1:0] stable_reg;

always @(posedge clk) begin
    if (sys_rst) begin
        meta_reg <= {W{1'b0}};
        stable_reg <= {W{1'b0}};
    end else begin
        meta_reg <= async_in;
        stable_reg <= meta_reg;
    end
end

assign sync_out = stable_reg;

endmodule

// ===== hdl/rtcs_top.v
// Purpose: Timekeeping core and serial access of a real-time clock
// Assumes: All pins asynchronous to clk; sclk period well above 6 clk
// Notes: Bytes written go through a FIFO into the counters
// Overview of operation
// - Interface select low picks three-wire, high picks SPI framing.
// - Serial clock supplied by host times every data bit both ways.
// - Power-fail output low while primary supply below backup or battery.
// - Fixed-zero bit positions always read zero whatever was written.
// - Reserved register locations ignore writes and read zero.
// - Time and calendar held and counted in BCD, one digit per nibble.
// - Day of week advances once at the midnight hours rollover.
// - Time registers have no defined power-on value.
// - Counting continues while a serial write is in progress.
// - Writing seconds restarts the sub-second countdown chain.
// - Chip enable dropped mid-byte discards that byte.
// - Read transfer start copies all time counters into a buffer.
// - Buffer stays frozen for the burst while counters keep running.
// - Hours bit six selects 12-hour mode; bit five is PM or tens.
`timescale 1ns/100ps
`include "rtcs_defines.vh"
module rtcs_top (
    // Clock and reset
    input wire clk,
    input wire sys_rst,
    // Serial pins
    input wire interface_select,
    input wire ce,
    input wire sclk,
    input wire sdi,
    output wire sdo,
    output wire sdo_oe,
    // Time base
    input wire osc_clk,
    input wire oscillator_disable,
    // Supply comparators
    input wire primary_below_backup,
    input wire primary_below_battery,
    output wire power_fail_n,
    // Status
    output wire write_dropped
);

// Synchronised pins
wire [7:0] pin_s;
wire spi_s, ce_s, sclk_s, sdi_s, osc_s, osc_off_s, fail_s;

rtcs_sync #(
    .W(8)
) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in({interface_select, ce, sclk, sdi, osc_clk,
        oscillator_disable, primary_below_backup,
        primary_below_battery}),
    .sync_out(pin_s)
);

assign spi_s = pin_s[7];
assign ce_s = pin_s[6];
assign sclk_s = pin_s[5];
assign sdi_s = pin_s[4];
assign osc_s = pin_s[3];
assign osc_off_s = pin_s[2];
assign fail_s = pin_s[1] | pin_s[0];

function [7:0] bit_rev;
    input [7:0] v;
    integer i;
    begin
        for (i = 0; i < 8; i = i + 1) begin
            bit_rev[i] = v[7-i];
        end
    end
endfunction

function [7:0] reg_mask;
    input [6:0] idx;
    begin
        case (idx)
            `RTCS_IDX_SEC: reg_mask = `RTCS_MASK_SEC;
            `RTCS_IDX_MIN: reg_mask = `RTCS_MASK_MIN;
            `RTCS_IDX_HOUR: reg_mask = `RTCS_MASK_HOUR;
            `RTCS_IDX_DOW: reg_mask = `RTCS_MASK_DOW;
            `RTCS_IDX_DATE: reg_mask = `RTCS_MASK_DATE;
            `RTCS_IDX_MON: reg_mask = `RTCS_MASK_MON;
            `RTCS_IDX_YEAR: reg_mask = `RTCS_MASK_YEAR;
            default: reg_mask = 8'h00;
        endcase
    end
endfunction

// BCD increment of a two-digit value
function [7:0] bcd_inc;
    input [7:0] v;
    begin
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    end
endfunction

// Last day of month, BCD, leap years from BCD year
function [7:0] last_day;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
            : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        case (mon)
            8'h02: last_day = leap ? 8'h29 : 8'h28;
            8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    end
endfunction

// Live counters and read buffer
reg [7:0] tm_reg [0:6];
reg [7:0] shadow_reg [0:6];
reg [14:0] presc_reg;
reg osc_d_reg, sclk_d_reg;

// Serial engine state
localparam PH_ADDR = 1'b0;
localparam PH_DATA = 1'b1;
reg phase_reg, rd_reg, oe_reg, fail_n_reg, drop_reg;
reg [6:0] addr_reg;
reg [2:0] cnt_reg;
reg [7:0] rx_reg, tx_reg;

wire sclk_rise, osc_rise, tick, byte_done;
wire [7:0] rx_next, rx_byte, wr_val;
wire fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
wire [`RTCS_FIFO_W-1:0] fifo_out_data;
wire [6:0] wr_idx;

assign sclk_rise = ce_s & sclk_s & ~sclk_d_reg;
assign osc_rise = osc_s & ~osc_d_reg;
assign tick = osc_rise & ~osc_off_s & (presc_reg == `RTCS_PRESC_MAX);
assign rx_next = {rx_reg[6:0], sdi_s};
assign rx_byte = spi_s ? rx_next : bit_rev(rx_next);
assign byte_done = sclk_rise & (cnt_reg == 3'h7);

// Complete write bytes to live registers only; reserved ones dropped
assign fifo_in_valid = byte_done & (phase_reg == PH_DATA) & ~rd_reg
    & (addr_reg < `RTCS_NUM_TIME);

// Read byte selection: live copy at address time, buffer afterwards
reg [6:0] rd_idx;
reg [7:0] rd_byte;
always @* begin
    if (phase_reg == PH_DATA) begin
        rd_idx = addr_reg + 7'h01;
    end else begin
        rd_idx = rx_byte[6:0];
    end
    rd_byte = 8'h00;
    if (rd_idx < `RTCS_NUM_TIME) begin
        if (phase_reg == PH_DATA) begin
            rd_byte = shadow_reg[rd_idx[2:0]] & reg_mask(rd_idx);
        end else begin
            rd_byte = tm_reg[rd_idx[2:0]] & reg_mask(rd_idx);
        end
    end
end

always @(posedge clk) begin
    if (sys_rst) begin
        phase_reg <= PH_ADDR;
        rd_reg <= 1'b0;
        addr_reg <= 7'h00;
        cnt_reg <= 3'h0;
        rx_reg <= 8'h00;
        tx_reg <= 8'h00;
        oe_reg <= 1'b0;
        sclk_d_reg <= 1'b0;
        drop_reg <= 1'b0;
    end else begin
        sclk_d_reg <= sclk_s;
        drop_reg <= fifo_in_valid & ~fifo_in_ready;
        if (!ce_s) begin
            // Partial byte and transfer state forgotten
            phase_reg <= PH_ADDR;
            rd_reg <= 1'b0;
            cnt_reg <= 3'h0;
            oe_reg <= 1'b0;
        end else if (sclk_rise) begin
            rx_reg <= rx_next;
            cnt_reg <= cnt_reg + 3'h1;
            if (cnt_reg == 3'h7) begin
                if (phase_reg == PH_ADDR) begin
                    phase_reg <= PH_DATA;
                    addr_reg <= rx_byte[6:0];
                    rd_reg <= ~rx_byte[`RTCS_ADDR_WR_BIT];
                    oe_reg <= ~rx_byte[`RTCS_ADDR_WR_BIT];
                    tx_reg <= spi_s ? rd_byte : bit_rev(rd_byte);
                end else begin
                    addr_reg <= addr_reg + 7'h01;
                    tx_reg <= spi_s ? rd_byte : bit_rev(rd_byte);
                end
            end else if (phase_reg == PH_DATA && rd_reg) begin
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
        end
    end
end

// Snapshot of the counters when a read address completes
integer s;
always @(posedge clk) begin
    if (byte_done && phase_reg == PH_ADDR
        && !rx_byte[`RTCS_ADDR_WR_BIT]) begin
        for (s = 0; s < 7; s = s + 1) begin
            shadow_reg[s] <= tm_reg[s];
        end
    end
end

// Pending writes wait while a tick is being applied
assign fifo_out_ready = ~tick;

rtcs_fifo #(
    .W(`RTCS_FIFO_W),
    .DEPTH(`RTCS_FIFO_D),
    .AW(`RTCS_FIFO_AW)
) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data({addr_reg, rx_byte}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
);

assign wr_idx = fifo_out_data[14:8];
assign wr_val = fifo_out_data[7:0] & reg_mask(wr_idx);

// Next values of the counting cascade
reg [7:0] sec_next, min_next, hour_next, dow_next;
reg [7:0] date_next, mon_next, year_next, hr12_inc, hr24_inc;
reg c_sec, c_min, c_day, c_mon;
always @* begin
    hr12_inc = bcd_inc({3'h0, tm_reg[2][4:0]});
    hr24_inc = bcd_inc({2'h0, tm_reg[2][5:0]});
    c_sec = (tm_reg[0] == 8'h59);
    sec_next = c_sec ? 8'h00 : bcd_inc(tm_reg[0]);
    c_min = (tm_reg[1] == 8'h59);
    min_next = c_min ? 8'h00 : bcd_inc(tm_reg[1]);
    hour_next = tm_reg[2];
    c_day = 1'b0;
    if (tm_reg[2][`RTCS_HOUR_MODE_BIT]) begin
        // Twelve-hour: 11 -> 12 flips PM, 11 PM -> 12 AM is midnight
        if (tm_reg[2][4:0] == 5'h12) begin
            hour_next[4:0] = 5'h01;
        end else if (tm_reg[2][4:0] == 5'h11) begin
            hour_next[4:0] = 5'h12;
            hour_next[`RTCS_HOUR_PM_BIT] = ~tm_reg[2][`RTCS_HOUR_PM_BIT];
            c_day = tm_reg[2][`RTCS_HOUR_PM_BIT];
        end else begin
            hour_next[4:0] = hr12_inc[4:0];
        end
    end else if (tm_reg[2][5:0] == 6'h23) begin
        hour_next[5:0] = 6'h00;
        c_day = 1'b1;
    end else begin
        hour_next[5:0] = hr24_inc[5:0];
    end
    dow_next = (tm_reg[3] == 8'h07) ? 8'h01 : tm_reg[3] + 8'h01;
    c_mon = (tm_reg[4] == last_day(tm_reg[5], tm_reg[6]));
    date_next = c_mon ? 8'h01 : bcd_inc(tm_reg[4]);
    mon_next = (tm_reg[5] == 8'h12) ? 8'h01 : bcd_inc(tm_reg[5]);
    year_next = (tm_reg[6] == 8'h99) ? 8'h00 : bcd_inc(tm_reg[6]);
end

// Counters are left unreset: their power-on value is undefined
always @(posedge clk) begin
    if (tick) begin
        tm_reg[0] <= sec_next;
        if (c_sec) begin
            tm_reg[1] <= min_next;
            if (c_min) begin
                tm_reg[2] <= hour_next;
                if (c_day) begin
                    tm_reg[3] <= dow_next;
                    tm_reg[4] <= date_next;
                    if (c_mon) begin
                        tm_reg[5] <= mon_next;
                        if (tm_reg[5] == 8'h12) begin
                            tm_reg[6] <= year_next;
                        end
                    end
                end
            end
        end
    end else if (fifo_out_valid) begin
        tm_reg[wr_idx[2:0]] <= wr_val;
    end
end

// Prescaler and supply status
always @(posedge clk) begin
    if (sys_rst) begin
        presc_reg <= 15'h0000;
        osc_d_reg <= 1'b0;
        fail_n_reg <= 1'b1;
    end else begin
        osc_d_reg <= osc_s;
        fail_n_reg <= ~fail_s;
        if (!tick && fifo_out_valid && wr_idx == `RTCS_IDX_SEC) begin
            presc_reg <= 15'h0000;
        end else if (osc_rise && !osc_off_s) begin
            presc_reg <= presc_reg + 15'h0001;
        end
    end
end

assign sdo = tx_reg[7];
assign sdo_oe = oe_reg;
assign power_fail_n = fail_n_reg;
assign write_dropped = drop_reg;

endmodule

// ===== tb/rtcs_host.sv
// Purpose: Host model driving the serial pins
// Assumes: mode is the strap level
// Notes: 4 clk each sclk phase, 80 ns a bit
`timescale 1ns/100ps
module rtcs_host (
    // Clock
    input logic clk,
    // Link
    input logic mode,
    input logic sdo,
    input logic sdo_oe,
    output logic ce,
    output logic sclk,
    output logic host_d
);
    initial begin
        ce = 1'h0;
        sclk = 1'h0;
        host_d = 1'h0;
    end
    // Device bit taken just before the rise
    task clk_bit(input logic b, output logic r);
        host_d <= b;
        repeat (4) @(posedge clk);
        r = sdo_oe ? sdo : 1'bx;
        sclk <= 1'h1;
        repeat (4) @(posedge clk);
        sclk <= 1'h0;
    endtask
    task byte_out(input logic [7:0] v);
        logic r;
        for (int i = 0; i < 8; i++)
            clk_bit(mode ? v[7 - i] : v[i], r);
    endtask
    // Released line shows the inverse of the last bit
    task byte_in(output logic [7:0] v);
        logic r;
        for (int i = 0; i < 8; i++) begin
            clk_bit(~host_d, r);
            v[mode ? 7 - i : i] = r;
        end
    endtask
    task start_x;
        ce <= 1'h1;
        repeat (4) @(posedge clk);
    endtask
    task stop_x;
        repeat (4) @(posedge clk);
        ce <= 1'h0;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ===== tb/rtcs_top_assertions.sv
// Purpose: Port checks of the serial clock core
// Assumes: Pins change on clk edges
// Notes: Bound to rtcs_top
`timescale 1ns/100ps
module rtcs_top_assertions (
    // Clock and reset
    input logic clk,
    input logic sys_rst,
    // Serial pins
    input logic ce,
    input logic sclk,
    input logic sdo,
    input logic sdo_oe,
    // Supply and status
    input logic primary_below_backup,
    input logic primary_below_battery,
    input logic power_fail_n,
    input logic write_dropped
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire supply_low = primary_below_backup | primary_below_battery;
    sequence s_low; supply_low [*5]; endsequence
    sequence s_ok; !supply_low [*5]; endsequence
    sequence s_idle; !ce [*6]; endsequence
    sequence s_quiet; (ce && !$rose(sclk)) [*6]; endsequence
    property p_fail_low; s_low |-> !power_fail_n; endproperty
    property p_fail_clear; s_ok |-> power_fail_n; endproperty
    property p_oe_idle; s_idle |-> !sdo_oe; endproperty
    property p_drop_idle; s_idle |-> !write_dropped; endproperty
    property p_sdo_quiet; s_quiet |-> $stable(sdo); endproperty
    property p_oe_rise; $rose(sdo_oe) |-> ce && $past(ce, 2); endproperty
    property p_oe_hold; sdo_oe && ce |=> sdo_oe; endproperty
    property p_oe_fall; $fell(sdo_oe) |-> !$past(ce, 2); endproperty
    a_fail_low: assert property (p_fail_low)
        else $error("power fail not shown");
    a_fail_clear: assert property (p_fail_clear)
        else $error("power fail shown wrongly");
    a_oe_idle: assert property (p_oe_idle)
        else $error("sdo driven while idle");
    a_drop_idle: assert property (p_drop_idle)
        else $error("write dropped while idle");
    a_sdo_quiet: assert property (p_sdo_quiet)
        else $error("sdo moved without sclk");
    a_oe_rise: assert property (p_oe_rise)
        else $error("sdo enabled outside transfer");
    a_oe_hold: assert property (p_oe_hold)
        else $error("sdo released mid burst");
    a_oe_fall: assert property (p_oe_fall)
        else $error("sdo released with ce high");
endmodule
bind rtcs_top rtcs_top_assertions u_chk (.clk(clk), .sys_rst(sys_rst),
    .ce(ce), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe),
    .primary_below_backup(primary_below_backup),
    .primary_below_battery(primary_below_battery),
    .power_fail_n(power_fail_n), .write_dropped(write_dropped));

// ===== tb/tb_top.sv
// Purpose: Self-checking bench of the serial clock core
// Assumes: osc_clk 25 ns, so one second is 81920 clk
// Notes: Rows, then abort, reset and rollover
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic md;
        logic [1:0] pw;
        logic [6:0] idx;
        logic [7:0] wv;
        logic [7:0] ev;
    } rtcs_row_t;
    localparam int SEC = 81920;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic mode = 1'h0;
    logic osc_clk = 1'h0;
    logic osc_off = 1'h0;
    logic [1:0] pw = 2'h0;
    logic ce, sclk, host_d, sdi, sdo, sdo_oe, power_fail_n, write_dropped;
    logic [7:0] buf_q [0:6];
    logic [7:0] exp_q [0:6];
    logic [7:0] got;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cyc = 0;
    int t_w;
    rtcs_row_t rows [0:8];
    always #5 clk = ~clk;
    always #12.5 osc_clk = ~osc_clk;
    assign sdi = (!mode && sdo_oe) ? sdo : host_d;
    rtcs_top dut (.clk(clk), .sys_rst(sys_rst), .interface_select(mode),
        .ce(ce), .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe),
        .osc_clk(osc_clk), .oscillator_disable(osc_off),
        .primary_below_backup(pw[1]), .primary_below_battery(pw[0]),
        .power_fail_n(power_fail_n), .write_dropped(write_dropped));
    rtcs_host host (.clk(clk), .mode(mode), .sdo(sdo), .sdo_oe(sdo_oe),
        .ce(ce), .sclk(sclk), .host_d(host_d));
    task close_out;
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    // Address byte, then n data bytes through buf_q
    task xfer(input logic [7:0] a, input int n);
        host.start_x;
        host.byte_out(a);
        for (int i = 0; i < n; i++) begin
            if (a[7])
                host.byte_out(buf_q[i]);
            else
                host.byte_in(buf_q[i]);
        end
        host.stop_x;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            n_mismatch++;
            close_out;
        end
    end
    initial begin
        rows[0] = {1'h0, 2'h0, 7'h01, 8'h59, 8'h59};
        rows[1] = {1'h1, 2'h1, 7'h02, 8'h72, 8'h72};
        rows[2] = {1'h0, 2'h2, 7'h03, 8'hf7, 8'h07};
        rows[3] = {1'h1, 2'h3, 7'h04, 8'hf1, 8'h31};
        rows[4] = {1'h0, 2'h0, 7'h05, 8'he9, 8'h09};
        rows[5] = {1'h1, 2'h2, 7'h12, 8'h5a, 8'h00};
        rows[6] = {1'h0, 2'h1, 7'h1f, 8'ha5, 8'h00};
        rows[7] = {1'h1, 2'h0, 7'h06, 8'h99, 8'h99};
        rows[8] = {1'h0, 2'h0, 7'h00, 8'hc5, 8'h45};
        repeat (6) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (4) @(posedge clk);
        chk({4'h0, sdo, sdo_oe, power_fail_n, write_dropped}, 8'h02);
        foreach (rows[k]) begin
            mode <= rows[k].md;
            pw <= rows[k].pw;
            @(posedge clk);
            buf_q[0] = rows[k].wv;
            xfer({1'h1, rows[k].idx}, 1);
            xfer({1'h0, rows[k].idx}, 1);
            chk(buf_q[0], rows[k].ev);
            chk({7'h0, power_fail_n}, {7'h0, ~|rows[k].pw});
        end
        // Minute byte cut after four bits
        host.start_x;
        host.byte_out(8'h81);
        for (int i = 0; i < 4; i++)
            host.clk_bit(1'h0, got[0]);
        host.stop_x;
        xfer(8'h01, 1);
        chk(buf_q[0], 8'h59);
        pw <= 2'h3;
        sys_rst <= 1'h1;
        repeat (6) @(posedge clk);
        chk({4'h0, sdo, sdo_oe, power_fail_n, write_dropped}, 8'h02);
        sys_rst <= 1'h0;
        pw <= 2'h0;
        repeat (4) @(posedge clk);
        // Seconds written last, then read across the tick
        buf_q = '{8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h01, 8'h00};
        xfer(8'h81, 6);
        buf_q[0] = 8'h59;
        xfer(8'h80, 1);
        t_w = cyc;
        // Oscillator held off 400 clk pushes the tick 400 later
        osc_off <= 1'h1;
        repeat (400) @(posedge clk);
        osc_off <= 1'h0;
        while (cyc < t_w + SEC + 100)
            @(posedge clk);
        xfer(8'h00, 7);
        exp_q = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h01};
        for (int i = 0; i < 7; i++)
            chk(buf_q[i], exp_q[i]);
        xfer(8'h00, 7);
        exp_q = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h01};
        for (int i = 0; i < 7; i++)
            chk(buf_q[i], exp_q[i]);
        close_out;
    end
endmodule
